/* rtl/frl_cfg.svh */
`ifndef FRL_CFG_SVH
`define FRL_CFG_SVH
// Register addresses on the plain register port
`define FRL_ADDR_CTRL 4'h0
`define FRL_ADDR_UPPER 4'h1
`define FRL_ADDR_LOWER 4'h2
`define FRL_ADDR_MASTER 4'h3
`define FRL_ADDR_JUMP1 4'h4
`define FRL_ADDR_JUMP2 4'h5
`define FRL_ADDR_JUMP3 4'h6
`define FRL_ADDR_WIDTH 4'h7
`define FRL_ADDR_BSTEP 4'h8
`define FRL_ADDR_STEP4 4'h9
`define FRL_ADDR_OPREF 4'hA
`define FRL_ADDR_BSTORE 4'hB
`define FRL_ADDR_OUTF 4'hC
`define FRL_ADDR_BIAS 4'hD
`define FRL_ADDR_UDREF 4'hE
`define FRL_ADDR_TARGET 4'hF
// Control register bit positions
`define FRL_CTRL_UPDOWN 0
`define FRL_CTRL_RHOLD 1
`define FRL_CTRL_HOLDSEL 2
`define FRL_CTRL_BRAMP 3
// Reset values (percent in 0.1 %, frequency in 0.01 Hz)
`define FRL_UPPER_RST 16'h03E8
`define FRL_WIDTH_RST 16'h0064
`define FRL_ZERO16 16'h0000
`define FRL_PCT_SCALE 32'h000003E8
// Timing: 1 ms tick, 5 s release delay
`define FRL_CLK_PERIOD_NS 4
`define FRL_TICK_NS 1000000
`define FRL_RELEASE_MS 5000
`endif

/* rtl/frl_freq_ref_limit.sv */
// Notes on behaviour
// - Reference never above upper percent limit
// - Reference below lower limit runs at limit
// - Start below lower limit accelerates to it
// - Master lower limit only for analog source
// - Jog and preset lower limits stay unaffected
// - Larger of both lower limits applies
// - Clamp below jump band until exceeded
// - All jump frequencies zero disables jumps
// - Ramp through band, never settle inside except at a ramp hold value
// - Hold select picks what is retained
// - Select zero: ramp hold value cleared
// - Select zero: up/down reference cleared
// - Select zero: bias never saved, restarts zero
// - Select one: hold value kept till release
// - Select one: up/down reference kept
// - Select one, operator source: bias folded after 5 s
// - Select one, other source: bias stored after 5 s
// - Hold release or idle up/down clears
// - Zero step: bias ramps while commanded
// - Nonzero step: one step per press
// - Bias ramp uses active or fourth time
//
// Decided for this implementation: the plain strobed port and the register offsets.
`include "frl_cfg.svh"
`default_nettype none
module frl_freq_ref_limit #(
  parameter int TICK_CYC = `FRL_TICK_NS / `FRL_CLK_PERIOD_NS,
  parameter int RELEASE_TICKS = `FRL_RELEASE_MS
) (
  input wire logic clk,                          // System clock
  input wire logic reset,                        // Asynchronous reset
  input wire logic [3:0] addr,                   // Register address
  input wire logic [15:0] wdata,                 // Register write data
  input wire logic wr,                           // Write strobe
  input wire logic rd,                           // Read strobe
  output logic [15:0] rdata,                     // Read data, cycle after strobe
  input wire frl_pkg::frl_term_t terms,          // Terminal pins, asynchronous
  input wire frl_pkg::frl_src_t ref_src,         // Active reference source
  input wire logic [15:0] analog_in_1,           // Analog reference 1
  input wire logic [15:0] analog_in_2,           // Analog reference 2
  input wire logic [15:0] preset_ref,            // Jog or multi-step reference
  input wire logic [15:0] fmax,                  // Maximum output frequency
  input wire logic [15:0] ramp_step_active,      // Active accel/decel step per tick
  output logic [15:0] out_freq                   // Ramped output frequency
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int RW = $clog2(RELEASE_TICKS + 1);

  // Scale a 0.1 % setting against the maximum frequency
  function automatic logic [15:0] pct_to_freq(input logic [15:0] pct, input logic [15:0] fm);
    logic [31:0] prod;
    prod = (32'(pct) * 32'(fm)) / `FRL_PCT_SCALE;
    pct_to_freq = (prod[31:16] != 16'h0000) ? 16'hFFFF : prod[15:0];
  endfunction

  // Push a frequency out of one jump band to just below it
  function automatic logic [15:0] jump_clamp(input logic [15:0] f, input logic [15:0] jf,
                                             input logic [15:0] w);
    logic [16:0] lo;
    logic [16:0] hi;
    lo = (jf > w) ? 17'(jf - w) : 17'h00000;
    hi = 17'(jf) + 17'(w);
    jump_clamp = f;
    if (jf != 16'h0000 && 17'(f) > lo && 17'(f) <= hi)
      jump_clamp = lo[15:0];
  endfunction

  // Saturate a signed sum into 0 .. FFFF
  function automatic logic [15:0] sat_u(input logic signed [18:0] v);
    if (v < 19'sh00000)
      sat_u = 16'h0000;
    else if (v > 19'sh0FFFF)
      sat_u = 16'hFFFF;
    else
      sat_u = v[15:0];
  endfunction

  // Saturate a signed sum into the bias range
  function automatic logic signed [16:0] sat_b(input logic signed [18:0] v);
    if (v < -19'sh0FFFF)
      sat_b = -17'sh0FFFF;
    else if (v > 19'sh0FFFF)
      sat_b = 17'sh0FFFF;
    else
      sat_b = v[16:0];
  endfunction

  frl_pkg::frl_term_t sync1_reg, sync2_reg, prev_reg;
  frl_pkg::frl_ctrl_t ctrl_reg;
  logic [15:0] upper_reg, lower_reg, master_reg, width_reg, bstep_reg, step4_reg;
  logic [15:0] jf_reg [3];
  logic [15:0] op_ref_reg, bias_store_reg, ud_ref_reg, hold_val_reg, target_reg;
  logic [15:0] out_reg, rdata_reg;
  logic signed [16:0] bias_reg, bias_prev_reg;
  logic hold_ok_reg, bias_busy_reg, pend_reg, fire_reg, tick_reg;
  logic [TW-1:0] tick_cnt_reg;
  logic [RW-1:0] rel_cnt_reg;

  // Terminal pins pass two flip-flops; edges come from the second
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      sync1_reg <= terms;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic run, run_rise, run_fall, bu, bd, bu_rise, bd_rise, any_bias, is_op, is_analog;
  assign run = sync2_reg.run;
  assign run_rise = run & ~prev_reg.run;
  assign run_fall = ~run & prev_reg.run;
  assign bu = sync2_reg.bias_up;
  assign bd = sync2_reg.bias_down;
  assign bu_rise = bu & ~prev_reg.bias_up;
  assign bd_rise = bd & ~prev_reg.bias_down;
  assign any_bias = bu | bd;
  assign is_op = (ref_src == frl_pkg::SRC_OPERATOR);
  assign is_analog = (ref_src == frl_pkg::SRC_ANALOG1) || (ref_src == frl_pkg::SRC_ANALOG2);

  // Millisecond tick from the system clock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == TW'(TICK_CYC - 1))
    begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // Software settings
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_reg <= '0;
      upper_reg <= `FRL_UPPER_RST;
      lower_reg <= `FRL_ZERO16;
      master_reg <= `FRL_ZERO16;
      jf_reg <= '{default: `FRL_ZERO16};
      width_reg <= `FRL_WIDTH_RST;
      bstep_reg <= `FRL_ZERO16;
      step4_reg <= `FRL_ZERO16;
    end
    else if (wr)
    begin
      unique case (addr)
        `FRL_ADDR_CTRL: ctrl_reg <= wdata[3:0];
        `FRL_ADDR_UPPER: upper_reg <= wdata;
        `FRL_ADDR_LOWER: lower_reg <= wdata;
        `FRL_ADDR_MASTER: master_reg <= wdata;
        `FRL_ADDR_JUMP1: jf_reg[0] <= wdata;
        `FRL_ADDR_JUMP2: jf_reg[1] <= wdata;
        `FRL_ADDR_JUMP3: jf_reg[2] <= wdata;
        `FRL_ADDR_WIDTH: width_reg <= wdata;
        `FRL_ADDR_BSTEP: bstep_reg <= wdata;
        `FRL_ADDR_STEP4: step4_reg <= wdata;
        default: ;
      endcase
    end
  end

  // Release delay: restarts on each bias command, fires once
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pend_reg <= 1'b0;
      rel_cnt_reg <= '0;
      fire_reg <= 1'b0;
    end
    else
    begin
      fire_reg <= 1'b0;
      if (any_bias)
      begin
        pend_reg <= 1'b1;
        rel_cnt_reg <= '0;
      end
      else if (run_fall)
        pend_reg <= 1'b0;
      else if (pend_reg && tick_reg)
      begin
        if (rel_cnt_reg == RW'(RELEASE_TICKS - 1))
        begin
          pend_reg <= 1'b0;
          fire_reg <= 1'b1;
        end
        else
          rel_cnt_reg <= rel_cnt_reg + 1'b1;
      end
    end
  end

  logic [15:0] bias_rate;
  assign bias_rate = ctrl_reg.bias_ramp_select ? step4_reg : ramp_step_active;

  // Up/down 2 bias value
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bias_reg <= '0;
    else if (run_fall && !ctrl_reg.hold_select)
      bias_reg <= '0;
    else if (run_rise)
      bias_reg <= (ctrl_reg.hold_select && !is_op) ? 17'(signed'(bias_store_reg)) : '0;
    else if (fire_reg && ctrl_reg.hold_select && is_op)
      bias_reg <= '0;
    else if (bstep_reg == 16'h0000)
    begin
      if (tick_reg && bu && !bd)
        bias_reg <= sat_b(19'(bias_reg) + 19'(bias_rate));
      else if (tick_reg && bd && !bu)
        bias_reg <= sat_b(19'(bias_reg) - 19'(bias_rate));
    end
    else if (bu_rise && !bd)
      bias_reg <= sat_b(19'(bias_reg) + 19'(bstep_reg));
    else if (bd_rise && !bu)
      bias_reg <= sat_b(19'(bias_reg) - 19'(bstep_reg));
  end

  // Operator reference: software write, bias folded after release
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      op_ref_reg <= `FRL_ZERO16;
    else if (fire_reg && ctrl_reg.hold_select && is_op)
      op_ref_reg <= sat_u(19'(op_ref_reg) + 19'(bias_reg));
    else if (wr && addr == `FRL_ADDR_OPREF)
      op_ref_reg <= wdata;
  end

  // Stored bias for sources other than the operator panel
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bias_store_reg <= `FRL_ZERO16;
    else if (fire_reg && ctrl_reg.hold_select && !is_op)
      bias_store_reg <= bias_reg[15:0];
    else if (wr && addr == `FRL_ADDR_BSTORE)
      bias_store_reg <= wdata;
  end

  // Up/down reference
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ud_ref_reg <= `FRL_ZERO16;
    else if (!ctrl_reg.updown_en)
      ud_ref_reg <= `FRL_ZERO16;
    else if (run_fall && !ctrl_reg.hold_select)
      ud_ref_reg <= `FRL_ZERO16;
    else if (!run && (sync2_reg.up || sync2_reg.down))
      ud_ref_reg <= `FRL_ZERO16;
    else if (run && tick_reg && sync2_reg.up && !sync2_reg.down)
      ud_ref_reg <= sat_u(19'(ud_ref_reg) + 19'(ramp_step_active));
    else if (run && tick_reg && sync2_reg.down && !sync2_reg.up)
      ud_ref_reg <= sat_u(19'(ud_ref_reg) - 19'(ramp_step_active));
  end

  // Ramp hold value
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hold_ok_reg <= 1'b0;
      hold_val_reg <= `FRL_ZERO16;
    end
    else if (!ctrl_reg.ramp_hold_en || !sync2_reg.hold)
    begin
      hold_ok_reg <= 1'b0;
      hold_val_reg <= `FRL_ZERO16;
    end
    else if (run_fall && !ctrl_reg.hold_select)
    begin
      hold_ok_reg <= 1'b0;
      hold_val_reg <= `FRL_ZERO16;
    end
    else if (run && !hold_ok_reg)
    begin
      hold_ok_reg <= 1'b1;
      hold_val_reg <= out_reg;
    end
  end

  // Reference selection, bias, limits and jump bands
  logic [15:0] base_ref, biased, hi_lim, lo_base, lo_master, lo_eff, limited, target_next;
  logic [15:0] jchain [4];
  logic jump_off;
  always_comb
  begin
    unique case (ref_src)
      frl_pkg::SRC_OPERATOR: base_ref = op_ref_reg;
      frl_pkg::SRC_ANALOG1: base_ref = analog_in_1;
      frl_pkg::SRC_ANALOG2: base_ref = analog_in_2;
      frl_pkg::SRC_PRESET: base_ref = preset_ref;
    endcase
    if (ctrl_reg.updown_en)
      base_ref = ud_ref_reg;
  end
  assign biased = sat_u(19'(base_ref) + 19'(bias_reg));
  assign hi_lim = pct_to_freq(upper_reg, fmax);
  assign lo_base = pct_to_freq(lower_reg, fmax);
  assign lo_master = is_analog ? pct_to_freq(master_reg, fmax) : 16'h0000;
  assign lo_eff = (lo_master > lo_base) ? lo_master : lo_base;
  // Lower limit first so the upper limit always wins
  assign limited = (((biased < lo_eff) ? lo_eff : biased) > hi_lim) ? hi_lim :
                   ((biased < lo_eff) ? lo_eff : biased);
  assign jchain[0] = limited;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_jump
      assign jchain[gi + 1] = jump_clamp(jchain[gi], jf_reg[gi], width_reg);
    end
  endgenerate
  assign jump_off = (jf_reg[0] == 16'h0000) && (jf_reg[1] == 16'h0000) && (jf_reg[2] == 16'h0000);
  always_comb
  begin
    target_next = jchain[3];
    if (hold_ok_reg)
      target_next = (hold_val_reg > hi_lim) ? hi_lim : hold_val_reg;
    if (!run)
      target_next = 16'h0000;
  end

  // Target and ramp toward it
  logic [15:0] ramp_rate;
  assign ramp_rate = (ctrl_reg.bias_ramp_select && (any_bias || bias_busy_reg)) ? step4_reg
                     : ramp_step_active;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      target_reg <= `FRL_ZERO16;
      out_reg <= `FRL_ZERO16;
    end
    else
    begin
      target_reg <= target_next;
      if (tick_reg && out_reg < target_reg)
        out_reg <= (target_reg - out_reg > ramp_rate) ? out_reg + ramp_rate : target_reg;
      else if (tick_reg && out_reg > target_reg)
        out_reg <= (out_reg - target_reg > ramp_rate) ? out_reg - ramp_rate : target_reg;
    end
  end

  // Bias-driven ramp lasts until the output reaches the target
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bias_busy_reg <= 1'b0;
      bias_prev_reg <= '0;
    end
    else
    begin
      bias_prev_reg <= bias_reg;
      if (bias_reg != bias_prev_reg)
        bias_busy_reg <= 1'b1;
      else if (out_reg == target_reg)
        bias_busy_reg <= 1'b0;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_reg <= `FRL_ZERO16;
    else if (rd)
    begin
      unique case (addr)
        `FRL_ADDR_CTRL: rdata_reg <= {12'h000, ctrl_reg};
        `FRL_ADDR_UPPER: rdata_reg <= upper_reg;
        `FRL_ADDR_LOWER: rdata_reg <= lower_reg;
        `FRL_ADDR_MASTER: rdata_reg <= master_reg;
        `FRL_ADDR_JUMP1: rdata_reg <= jf_reg[0];
        `FRL_ADDR_JUMP2: rdata_reg <= jf_reg[1];
        `FRL_ADDR_JUMP3: rdata_reg <= jf_reg[2];
        `FRL_ADDR_WIDTH: rdata_reg <= width_reg;
        `FRL_ADDR_BSTEP: rdata_reg <= bstep_reg;
        `FRL_ADDR_STEP4: rdata_reg <= step4_reg;
        `FRL_ADDR_OPREF: rdata_reg <= op_ref_reg;
        `FRL_ADDR_BSTORE: rdata_reg <= bias_store_reg;
        `FRL_ADDR_OUTF: rdata_reg <= out_reg;
        `FRL_ADDR_BIAS: rdata_reg <= bias_reg[15:0];
        `FRL_ADDR_UDREF: rdata_reg <= ud_ref_reg;
        `FRL_ADDR_TARGET: rdata_reg <= target_reg;
      endcase
    end
    else
      rdata_reg <= `FRL_ZERO16;
  end
  assign rdata = rdata_reg;
  assign out_freq = out_reg;

  // Checks on limits, jumps, hold and bias
  a_upper_clamp: assert property (@(posedge clk) disable iff (reset)
    target_reg <= $past(hi_lim)) else $error("target above upper limit");
  a_lower_clamp: assert property (@(posedge clk) disable iff (reset)
    $past(run) && $past(jump_off) && !$past(hold_ok_reg) && $past(lo_eff) <= $past(hi_lim)
    |-> target_reg >= $past(lo_eff)) else $error("target below lower limit");
  a_lower_pick: assert property (@(posedge clk) disable iff (reset)
    lo_eff == ((is_analog && lo_master > lo_base) ? lo_master : lo_base))
    else $error("wrong effective lower limit");
  a_jump_disabled: assert property (@(posedge clk) disable iff (reset)
    jump_off |-> jchain[3] == limited) else $error("jump active with all zero");
  a_jump_band: assert property (@(posedge clk) disable iff (reset)
    jf_reg[2] != 16'h0000 |-> !(17'(jchain[3]) + 17'(width_reg) > 17'(jf_reg[2])
    && 17'(jchain[3]) <= 17'(jf_reg[2]) + 17'(width_reg))) else $error("reference inside jump band");
  a_ramp_rate: assert property (@(posedge clk) disable iff (reset)
    !$past(tick_reg) |-> $stable(out_reg)) else $error("output moved without tick");
  a_ud_cancel: assert property (@(posedge clk) disable iff (reset)
    run_fall && ctrl_reg.updown_en && !ctrl_reg.hold_select |=> ud_ref_reg == 16'h0000)
    else $error("up/down reference kept after cancel");
  a_bias_store: assert property (@(posedge clk) disable iff (reset)
    fire_reg && ctrl_reg.hold_select && !is_op |=> bias_store_reg == $past(bias_reg[15:0]))
    else $error("bias not stored after release");
  a_bias_fold: assert property (@(posedge clk) disable iff (reset)
    fire_reg && ctrl_reg.hold_select && is_op && !run_fall && !run_rise |=> bias_reg == 17'sh00000)
    else $error("bias not cleared after fold");
  a_bias_step: assert property (@(posedge clk) disable iff (reset)
    bu_rise && !bd && bstep_reg != 16'h0000 && !run_fall && !run_rise && !fire_reg
    |=> bias_reg == sat_b(19'($past(bias_reg)) + 19'($past(bstep_reg))))
    else $error("bias step wrong");
  a_bias_nosave: assert property (@(posedge clk) disable iff (reset)
    run_fall && !ctrl_reg.hold_select |=> bias_reg == 17'sh00000 && $stable(bias_store_reg))
    else $error("bias saved with hold off");
  a_hold_release: assert property (@(posedge clk) disable iff (reset)
    !sync2_reg.hold |=> !hold_ok_reg) else $error("hold value kept after release");
  a_hold_cancel: assert property (@(posedge clk) disable iff (reset)
    run_fall && !ctrl_reg.hold_select |=> !hold_ok_reg) else $error("hold value kept after cancel");
endmodule : frl_freq_ref_limit
`default_nettype wire

/* rtl/frl_pkg.sv */
`default_nettype none
package frl_pkg;
  // Digital input terminals
  typedef struct packed {
    logic run;
    logic hold;
    logic up;
    logic down;
    logic bias_up;
    logic bias_down;
  } frl_term_t;
  // Active frequency reference source
  typedef enum logic [1:0] {
    SRC_OPERATOR,
    SRC_ANALOG1,
    SRC_ANALOG2,
    SRC_PRESET
  } frl_src_t;
  // Control register fields
  typedef struct packed {
    logic bias_ramp_select;
    logic hold_select;
    logic ramp_hold_en;
    logic updown_en;
  } frl_ctrl_t;
endpackage : frl_pkg
`default_nettype wire

/* sim/frl_freq_ref_limit_tb_top.sv */
`include "frl_cfg.svh"
`default_nettype none
module frl_freq_ref_limit_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [15:0] fmax = 16'h2710;
  logic [15:0] ramp_step_active = 16'h0100;
  logic [15:0] out_freq;
  logic [15:0] a1_req = 16'h0000;
  logic [15:0] a2_req = 16'h0000;
  logic [15:0] pre_req = 16'h0000;
  logic [15:0] d;
  frl_pkg::frl_term_t pin_req = '0;
  frl_pkg::frl_src_t src_req = frl_pkg::SRC_ANALOG1;
  frl_pkg::frl_term_t terms;
  frl_pkg::frl_src_t ref_src;
  logic [15:0] analog_in_1;
  logic [15:0] analog_in_2;
  logic [15:0] preset_ref;
  int n_errors = 0;
  int check_count = 0;
  logic [15:0] jin [5] = '{16'h1388, 16'h13EC, 16'h13ED, 16'h0BB8, 16'h07D0};
  logic [15:0] jexp [5] = '{16'h1324, 16'h1324, 16'h13ED, 16'h0B54, 16'h076C};
  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  frl_pin_model frl_pin_model_i (.clk(clk), .reset(reset), .pin_req(pin_req), .src_req(src_req),
    .a1_req(a1_req), .a2_req(a2_req), .pre_req(pre_req), .terms(terms), .ref_src(ref_src),
    .analog_in_1(analog_in_1), .analog_in_2(analog_in_2), .preset_ref(preset_ref));
  frl_freq_ref_limit #(.TICK_CYC(4), .RELEASE_TICKS(5)) frl_freq_ref_limit_i (.clk(clk), .reset(reset),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .terms(terms), .ref_src(ref_src),
    .analog_in_1(analog_in_1), .analog_in_2(analog_in_2), .preset_ref(preset_ref), .fmax(fmax),
    .ramp_step_active(ramp_step_active), .out_freq(out_freq));
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data are taken in the single cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // Read one register and compare it
  task automatic chk_reg(input logic [3:0] a, input logic [15:0] exp);
    rd_reg(a);
    chk(d, exp);
  endtask
  // Target settles a few cycles after a source change
  task automatic chk_tgt(input logic [15:0] exp);
    wcyc(6);
    chk_reg(`FRL_ADDR_TARGET, exp);
  endtask
  task automatic wait_out(input logic [15:0] exp);
    int i;
    // Output is looked at a moment after the edge that updates it
    for (i = 0; i < 400 && out_freq !== exp; i++)
    begin
      @(posedge clk);
      #1;
    end
    chk(out_freq, exp);
    if (out_freq !== exp)
      conclude();
  endtask
  task automatic bias_up_pulse(input int n);
    @(posedge clk);
    pin_req.bias_up <= 1'b1;
    wcyc(n);
    pin_req.bias_up <= 1'b0;
  endtask
  task automatic set_run(input logic v);
    @(posedge clk);
    pin_req.run <= v;
    wcyc(8);
  endtask
  // Main sequence
  initial
  begin
    wcyc(10);
    reset <= 1'b0;
    for (int a = 0; a < 16; a++)
      chk_reg(a[3:0], a == 1 ? `FRL_UPPER_RST : (a == 7 ? `FRL_WIDTH_RST : 16'h0000));
    set_run(1'b1);
    wr_reg(`FRL_ADDR_UPPER, 16'h01F4);
    a1_req <= 16'h1F40;
    chk_tgt(16'h1388);
    @(posedge clk);
    fmax <= 16'h1F40;
    chk_tgt(16'h0FA0);
    @(posedge clk);
    fmax <= 16'h2710;
    wr_reg(`FRL_ADDR_UPPER, 16'h03E8);
    wr_reg(`FRL_ADDR_LOWER, 16'h00C8);
    a1_req <= 16'h03E8;
    chk_tgt(16'h07D0);
    wait_out(16'h07D0);
    wr_reg(`FRL_ADDR_MASTER, 16'h012C);
    chk_tgt(16'h0BB8);
    src_req <= frl_pkg::SRC_PRESET;
    pre_req <= 16'h03E8;
    chk_tgt(16'h07D0);
    src_req <= frl_pkg::SRC_ANALOG2;
    a2_req <= 16'h03E8;
    chk_tgt(16'h0BB8);
    src_req <= frl_pkg::SRC_ANALOG1;
    wr_reg(`FRL_ADDR_LOWER, 16'h0000);
    wr_reg(`FRL_ADDR_MASTER, 16'h0000);
    a1_req <= 16'h0064;
    chk_tgt(16'h0064);
    // Descending jump frequencies, as software must program them
    wr_reg(`FRL_ADDR_JUMP1, 16'h1388);
    wr_reg(`FRL_ADDR_JUMP2, 16'h0BB8);
    wr_reg(`FRL_ADDR_JUMP3, 16'h07D0);
    for (int k = 0; k < 5; k++)
    begin
      a1_req <= jin[k];
      chk_tgt(jexp[k]);
    end
    wait_out(16'h076C);
    // Up/down reference kept or dropped over a run stop
    wr_reg(`FRL_ADDR_CTRL, 16'h0005);
    @(posedge clk);
    pin_req.up <= 1'b1;
    wcyc(20);
    pin_req.up <= 1'b0;
    set_run(1'b0);
    rd_reg(`FRL_ADDR_UDREF);
    chk(16'(d != 16'h0000), 16'h0001);
    @(posedge clk);
    pin_req.up <= 1'b1;
    wcyc(8);
    pin_req.up <= 1'b0;
    chk_reg(`FRL_ADDR_UDREF, 16'h0000);
    wr_reg(`FRL_ADDR_CTRL, 16'h0001);
    set_run(1'b1);
    pin_req.up <= 1'b1;
    wcyc(20);
    pin_req.up <= 1'b0;
    rd_reg(`FRL_ADDR_UDREF);
    chk(16'(d != 16'h0000), 16'h0001);
    set_run(1'b0);
    chk_reg(`FRL_ADDR_UDREF, 16'h0000);
    // Bias stepping, folding and storing
    wr_reg(`FRL_ADDR_CTRL, 16'h0004);
    wr_reg(`FRL_ADDR_BSTEP, 16'h0032);
    src_req <= frl_pkg::SRC_OPERATOR;
    wr_reg(`FRL_ADDR_OPREF, 16'h0BB8);
    set_run(1'b1);
    bias_up_pulse(8);
    chk_reg(`FRL_ADDR_BIAS, 16'h0032);
    wcyc(40);
    chk_reg(`FRL_ADDR_OPREF, 16'h0BEA);
    chk_reg(`FRL_ADDR_BIAS, 16'h0000);
    set_run(1'b0);
    src_req <= frl_pkg::SRC_ANALOG1;
    set_run(1'b1);
    bias_up_pulse(8);
    chk_reg(`FRL_ADDR_BSTORE, 16'h0000);
    wcyc(40);
    chk_reg(`FRL_ADDR_BSTORE, 16'h0032);
    set_run(1'b0);
    wr_reg(`FRL_ADDR_CTRL, 16'h0000);
    set_run(1'b1);
    chk_reg(`FRL_ADDR_BIAS, 16'h0000);
    wr_reg(`FRL_ADDR_BSTEP, 16'h0000);
    bias_up_pulse(20);
    rd_reg(`FRL_ADDR_BIAS);
    chk(16'(d != 16'h0000), 16'h0001);
    wcyc(40);
    chk_reg(`FRL_ADDR_BSTORE, 16'h0032);
    chk_reg(`FRL_ADDR_BIAS, 16'h0500);
    // Ramp hold kept over a stop with select one, dropped on release
    set_run(1'b0);
    wr_reg(`FRL_ADDR_CTRL, 16'h0006);
    set_run(1'b1);
    wait_out(16'h076C);
    @(posedge clk);
    pin_req.hold <= 1'b1;
    wcyc(8);
    a1_req <= 16'h0BB8;
    chk_tgt(16'h076C);
    set_run(1'b0);
    set_run(1'b1);
    chk_tgt(16'h076C);
    pin_req.hold <= 1'b0;
    chk_tgt(16'h0B54);
    conclude();
  end
endmodule // frl_freq_ref_limit_tb_top
`default_nettype wire

/* sim/frl_pin_model.sv */
`default_nettype none
// Terminal pins and analog sources seen by the block; pins read low when released
module frl_pin_model (
  input wire logic clk,                     // System clock
  input wire logic reset,                   // Asynchronous reset
  input wire frl_pkg::frl_term_t pin_req,   // Requested pin levels
  input wire frl_pkg::frl_src_t src_req,    // Requested reference source
  input wire logic [15:0] a1_req,           // Requested analog 1 level
  input wire logic [15:0] a2_req,           // Requested analog 2 level
  input wire logic [15:0] pre_req,          // Requested preset reference
  output frl_pkg::frl_term_t terms,         // Terminal pins
  output frl_pkg::frl_src_t ref_src,        // Active source
  output logic [15:0] analog_in_1,          // Analog reference 1
  output logic [15:0] analog_in_2,          // Analog reference 2
  output logic [15:0] preset_ref            // Preset reference
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins and sources follow requests one edge later, idle after reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      terms <= '0;
      ref_src <= frl_pkg::SRC_OPERATOR;
      analog_in_1 <= 16'h0000;
      analog_in_2 <= 16'h0000;
      preset_ref <= 16'h0000;
    end
    else
    begin
      terms <= pin_req;
      ref_src <= src_req;
      analog_in_1 <= a1_req;
      analog_in_2 <= a2_req;
      preset_ref <= pre_req;
    end
  end
endmodule // frl_pin_model
`default_nettype wire
